// ===== pcm_bus_host.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_bus_host (
    // clock
    input wire logic mclk,
    // target side
    input wire logic sda_oe,
    input wire logic sda_out,
    // bus lines
    output logic scl,
    output logic sda
);
    logic pull;
    // released line floats to the pull-up level
    assign sda = (pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // set both lines, then hold them for n clocks
    task automatic seg(input logic c, input logic p, input int n);
        scl <= c;
        pull <= p;
        repeat (n) @(posedge mclk);
    endtask : seg
    // data moves mid low phase and is read mid high phase
    task automatic bit_io(input logic b, output logic got);
        seg(1'b0, pull, 4);
        seg(1'b0, !b, 4);
        seg(1'b1, !b, 4);
        got = sda;
        seg(1'b1, !b, 4);
    endtask : bit_io
    task automatic start_cond();
        seg(1'b0, pull, 4);
        seg(1'b0, 1'b0, 4);
        seg(1'b1, 1'b0, 4);
        seg(1'b1, 1'b1, 4);
    endtask : start_cond
    task automatic stop_cond();
        seg(1'b0, pull, 4);
        seg(1'b0, 1'b1, 4);
        seg(1'b1, 1'b1, 4);
        seg(1'b1, 1'b0, 8);
    endtask : stop_cond
    // out-of-spec short clock
    task automatic runt();
        seg(1'b0, pull, 1);
        seg(1'b1, pull, 3);
    endtask : runt
    task automatic hold_low();
        seg(1'b0, pull, 1);
    endtask : hold_low
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], d);
        end
        bit_io(1'b1, d);
        ack = !d;
    endtask : send_byte
    task automatic recv_byte(input logic nack, output logic [7:0] v);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(nack, d);
    endtask : recv_byte
endmodule : pcm_bus_host
`default_nettype wire

// ===== pcm_ctrl.sv
// Overview of operation
// [R1] main rail on only while request low
// [R2] request high or open turns outputs off
// [R3] main off within 5 ms
// [R4] main on 5 to 400 ms after request
// [R5] power good off within 5 ms
// [R6] power good only when all regulated
// [R7] power good low on regulation or input loss
// [R8] good delay 100-500 ms, held in limit
// [R9] input good follows input range
// [R10] input good falls within 2 ms
// [R11] unit_n_a line low means installed
// [R12] target runs 100 kbps, no stretching
// [R13] clock stretch below 25 ms
// [R14] clock low over 25 ms aborts
// [R15] start and stop seen anywhere
// [R16] bad timing never locks up
// [R17] resynchronise at start or stop
// [R18] 256 byte identification store
// [R19] straps select both addresses
// [R20] fault latch cleared by toggle or input loss
// [R21] host spaces commands 1 ms apart
// [R22] request and straps debounced
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.svh"
module pcm_ctrl #(
    parameter int unsigned ON_DELAY_CYC = `PCM_ON_DELAY_CYC,
    parameter int unsigned GOOD_DELAY_CYC = `PCM_GOOD_DELAY_CYC,
    parameter int unsigned CLOCK_LOW_CYC = `PCM_CLOCK_LOW_CYC,
    parameter int unsigned RECOVER_CYC = `PCM_RECOVER_CYC,
    parameter int unsigned HOLDUP_CYC = `PCM_HOLDUP_CYC,
    parameter int unsigned DEBOUNCE_CYC = `PCM_DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system pins
    input wire logic power_on_request_n,
    input wire logic slot_addr_bit0,
    input wire logic slot_addr_bit1,
    output logic power_good,
    output logic input_good,
    output logic unit_n_a,
    // management bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // power stage
    input wire logic input_in_range,
    input wire logic rails_in_regulation,
    input wire logic rail_current_limit,
    input wire logic rail_overvoltage,
    input wire logic rail_short,
    output logic main_rail_enable
);
    import pcm_pkg::*;
    initial
        if (ON_DELAY_CYC < 1 || GOOD_DELAY_CYC < 1 || CLOCK_LOW_CYC < 1 || RECOVER_CYC < 1 ||
            HOLDUP_CYC < 1 || DEBOUNCE_CYC < 1 || DEBOUNCE_CYC > 65535)
            $error("timing parameter out of range");
    // three-flop synchronisers with debounce on the slow pins
    localparam int NSLOW = 4;
    logic [NSLOW-1:0] slow_pin;
    logic [NSLOW-1:0] slow_db;
    assign slow_pin = {input_in_range, slot_addr_bit1, slot_addr_bit0, power_on_request_n};
    generate
        for (genvar gi = 0; gi < NSLOW; gi++) begin : g_slow
            logic [2:0] sync;
            logic [15:0] stable_cnt;
            wire agree = (sync[1] == sync[2]);
            always_ff @(posedge mclk) begin
                if (reset) begin
                    sync <= 3'h7;
                    stable_cnt <= 16'h0000;
                    slow_db[gi] <= 1'b1; // open request reads as off [R2]
                end else begin
                    sync <= {sync[1:0], slow_pin[gi]};
                    if (!agree || sync[2] == slow_db[gi]) begin
                        stable_cnt <= 16'h0000;
                    end else if (stable_cnt == 16'(DEBOUNCE_CYC - 1)) begin
                        slow_db[gi] <= sync[2]; // [R22]
                        stable_cnt <= 16'h0000;
                    end else begin
                        stable_cnt <= stable_cnt + 16'h0001;
                    end
                end
            end
        end
    endgenerate
    wire request_on = ~slow_db[0]; // [R1]
    wire [1:0] slot = {slow_db[2], slow_db[1]};
    wire input_ok = slow_db[3];
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_f;
    logic sda_f;
    always_ff @(posedge mclk) begin
        if (reset) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            if (scl_sync[1] == scl_sync[2])
                scl_f <= scl_sync[2];
            if (sda_sync[1] == sda_sync[2])
                sda_f <= sda_sync[2];
        end
    end
    pcm_seq_t seq;
    pcm_seq_t next_seq;
    logic [31:0] seq_cnt;
    logic [31:0] holdup_cnt;
    logic input_lost;
    wire fault = rail_overvoltage | rail_short;
    wire holdup_done = input_lost && holdup_cnt == HOLDUP_CYC - 1;
    wire good_hold = ~rails_in_regulation | rail_current_limit; // [R8]
    wire on_delay_done = seq_cnt == ON_DELAY_CYC - 1;
    wire good_delay_done = seq_cnt == GOOD_DELAY_CYC - 1;
    always_comb begin
        next_seq = seq;
        unique case (seq)
            PCM_SEQ_OFF: if (request_on && input_ok) next_seq = PCM_SEQ_DELAY;
            PCM_SEQ_DELAY: if (on_delay_done) next_seq = PCM_SEQ_RAMP; // [R4]
            PCM_SEQ_RAMP:
                if (fault)
                    next_seq = PCM_SEQ_LATCH;
                else if (good_delay_done && !good_hold)
                    next_seq = PCM_SEQ_GOOD; // [R8]
            PCM_SEQ_GOOD:
                if (fault)
                    next_seq = PCM_SEQ_LATCH;
                else if (!rails_in_regulation)
                    next_seq = PCM_SEQ_RAMP; // [R7]
            PCM_SEQ_LATCH: ;
            default: next_seq = PCM_SEQ_OFF;
        endcase
        // request off or long input loss wins and clears the latch
        if (!request_on || holdup_done || (seq == PCM_SEQ_LATCH && !input_ok))
            next_seq = PCM_SEQ_OFF; // [R2] [R3] [R20]
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            seq <= PCM_SEQ_OFF;
            seq_cnt <= 32'h0;
            holdup_cnt <= 32'h0;
            input_lost <= 1'b0;
        end else begin
            seq <= next_seq;
            if (next_seq != seq || (seq == PCM_SEQ_RAMP && good_hold))
                seq_cnt <= 32'h0; // good delay restarts while any rail limits [R8]
            else if (!on_delay_done || seq != PCM_SEQ_DELAY)
                seq_cnt <= seq_cnt + 32'h1;
            input_lost <= ~input_ok & ~holdup_done;
            if (input_ok || holdup_done)
                holdup_cnt <= 32'h0;
            else
                holdup_cnt <= holdup_cnt + 32'h1; // [R7]
        end
    end
    // outputs: the off path takes only the debounce time, far under 5 ms
    always_ff @(posedge mclk) begin
        if (reset) begin
            main_rail_enable <= 1'b0;
            power_good <= 1'b0;
            input_good <= 1'b0;
        end else begin
            main_rail_enable <= next_seq == PCM_SEQ_RAMP || next_seq == PCM_SEQ_GOOD; // [R1] [R3]
            power_good <= next_seq == PCM_SEQ_GOOD && rails_in_regulation; // [R5] [R6]
            input_good <= input_ok; // [R9] [R10]
        end
    end
    // unit_n_a line is tied to output ground inside the unit [R11]
    assign unit_n_a = 1'b0;
    logic [1:0] ctrl;
    logic [7:0] apb_ptr;
    logic [7:0] store [256]; // [R18]
    wire apb_wr = psel & penable & pwrite;
    wire hit_ctrl = paddr == `PCM_REG_CTRL;
    wire hit_status = paddr == `PCM_REG_STATUS;
    wire hit_ptr = paddr == `PCM_REG_STORE_PTR;
    wire hit_data = paddr == `PCM_REG_STORE_DATA;
    wire hit_any = hit_ctrl | hit_status | hit_ptr | hit_data;
    wire bus_en = ctrl[`PCM_CTRL_BUS_EN];
    wire store_wr_en = ctrl[`PCM_CTRL_STORE_WR_EN];
    pcm_bus_t bst;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic is_read;
    logic to_store;
    logic first_byte;
    logic nack_seen;
    logic [7:0] bus_ptr;
    logic [7:0] cmd_code;
    logic scl_q;
    logic sda_q;
    logic [31:0] low_cnt;
    logic [31:0] recover_cnt;
    logic drive_low;
    wire scl_rise = scl_f & ~scl_q;
    wire scl_fall = ~scl_f & scl_q;
    wire start_cond = scl_f & scl_q & sda_q & ~sda_f; // [R15]
    wire stop_cond = scl_f & scl_q & ~sda_q & sda_f; // [R15]
    wire clock_stuck = low_cnt == CLOCK_LOW_CYC - 1;
    wire recovering = recover_cnt != 32'h0;
    wire [7:0] mgmt_addr = `PCM_MGMT_ADDR_BASE | {5'h00, slot, 1'b0}; // [R19]
    wire [7:0] store_addr = `PCM_STORE_ADDR_BASE | {5'h00, slot, 1'b0}; // [R19]
    wire [7:0] status_byte = {1'b0, seq == PCM_SEQ_OFF, rail_overvoltage, rail_current_limit, ~input_ok,
                              2'b00, seq == PCM_SEQ_LATCH};
    wire [7:0] tx_byte = to_store ? store[bus_ptr] : (cmd_code == 8'h00 ? 8'h00 : status_byte);
    wire bus_store_wr = bst == PCM_BUS_WRITE && scl_fall && bit_cnt == 4'h8 && to_store && !first_byte;
    wire addr_match = shreg[7:1] == mgmt_addr[7:1] || shreg[7:1] == store_addr[7:1];
    always_ff @(posedge mclk) begin
        if (reset) begin
            bst <= PCM_BUS_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            is_read <= 1'b0;
            to_store <= 1'b0;
            first_byte <= 1'b0;
            nack_seen <= 1'b0;
            bus_ptr <= 8'h00;
            cmd_code <= 8'h00;
            drive_low <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
            if (clock_stuck || !bus_en || stop_cond) begin
                bst <= PCM_BUS_IDLE; // abort and release the data line [R14] [R17]
                drive_low <= 1'b0;
            end else if (start_cond) begin
                bst <= recovering ? PCM_BUS_IDLE : PCM_BUS_ADDR; // [R14] [R17]
                bit_cnt <= 4'h0;
                drive_low <= 1'b0;
            end else begin
                // every state exits on start or stop, so stray edges cannot hang it [R16]
                unique case (bst)
                    PCM_BUS_IDLE: ;
                    PCM_BUS_ADDR, PCM_BUS_WRITE: begin
                        if (scl_rise && bit_cnt != 4'h8) begin
                            shreg <= {shreg[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            if (bst == PCM_BUS_ADDR) begin
                                if (addr_match) begin
                                    bst <= PCM_BUS_ACK;
                                    drive_low <= 1'b1;
                                    is_read <= shreg[0];
                                    to_store <= shreg[7:1] == store_addr[7:1];
                                    first_byte <= ~shreg[0];
                                end else
                                    bst <= PCM_BUS_IDLE;
                            end else begin
                                bst <= PCM_BUS_ACK;
                                drive_low <= 1'b1;
                                first_byte <= 1'b0;
                                if (first_byte && to_store)
                                    bus_ptr <= shreg;
                                else if (first_byte)
                                    cmd_code <= shreg;
                                else if (to_store)
                                    bus_ptr <= bus_ptr + 8'h01;
                            end
                        end
                    end
                    PCM_BUS_ACK:
                        if (scl_fall) begin
                            if (is_read) begin
                                bst <= PCM_BUS_READ;
                                shreg <= {tx_byte[6:0], 1'b0};
                                drive_low <= ~tx_byte[7];
                                bit_cnt <= 4'h1;
                            end else begin
                                bst <= PCM_BUS_WRITE;
                                drive_low <= 1'b0;
                            end
                        end
                    PCM_BUS_READ:
                        if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                bst <= PCM_BUS_RACK;
                                drive_low <= 1'b0;
                                bus_ptr <= bus_ptr + {7'h00, to_store};
                            end else begin
                                drive_low <= ~shreg[7];
                                shreg <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    PCM_BUS_RACK:
                        if (scl_rise) begin
                            nack_seen <= sda_f;
                        end else if (scl_fall) begin
                            if (nack_seen)
                                bst <= PCM_BUS_IDLE;
                            else begin
                                bst <= PCM_BUS_READ;
                                shreg <= {tx_byte[6:0], 1'b0};
                                drive_low <= ~tx_byte[7];
                                bit_cnt <= 4'h1;
                            end
                        end
                    default:
                        bst <= PCM_BUS_IDLE;
                endcase
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            low_cnt <= 32'h0;
            recover_cnt <= 32'h0;
        end else begin
            if (scl_f || clock_stuck)
                low_cnt <= 32'h0;
            else if (bst != PCM_BUS_IDLE)
                low_cnt <= low_cnt + 32'h1; // [R14]
            if (clock_stuck)
                recover_cnt <= RECOVER_CYC;
            else if (recovering)
                recover_cnt <= recover_cnt - 32'h1; // [R14]
        end
    end
    // scl is never held: the target keeps pace at 100 kbps with zero stretch [R12] [R13]
    assign sda_out = 1'b0;
    assign sda_oe = drive_low;
    // identification store, apb write wins a same-cycle collision
    always_ff @(posedge mclk) begin
        if (apb_wr && hit_data)
            store[apb_ptr] <= pwdata[7:0];
        else if (bus_store_wr && store_wr_en)
            store[bus_ptr] <= shreg;
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl <= `PCM_CTRL_RESET;
            apb_ptr <= 8'h00;
        end else if (apb_wr) begin
            if (hit_ctrl)
                ctrl <= pwdata[1:0];
            if (hit_ptr)
                apb_ptr <= pwdata[7:0];
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    wire [31:0] status_word = {11'h000, slot, bst == PCM_BUS_IDLE, recovering, seq, 9'h000, input_good, power_good,
                               main_rail_enable};
    assign prdata = hit_ctrl ? {30'h0, ctrl} : hit_status ? status_word : hit_ptr ? {24'h0, apb_ptr} :
                    hit_data ? {24'h0, store[apb_ptr]} : 32'h0;
endmodule : pcm_ctrl
`default_nettype wire

// ===== pcm_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_ctrl_monitor #(
    parameter int unsigned ON_DELAY_CYC = 200,
    parameter int unsigned GOOD_DELAY_CYC = 400,
    parameter int unsigned CLOCK_LOW_CYC = 3000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // system pins
    input wire logic power_on_request_n,
    input wire logic power_good,
    input wire logic input_good,
    input wire logic main_rail_enable,
    // power stage
    input wire logic input_in_range,
    input wire logic rails_in_regulation,
    input wire logic rail_current_limit,
    input wire logic rail_overvoltage,
    input wire logic rail_short,
    // bus
    input wire logic scl_in,
    input wire logic sda_oe
);
    int unsigned req_cnt, reg_cnt, low_cnt;
    // counters saturate so a long run never wraps back into range
    function automatic int unsigned sat(input int unsigned c);
        return c < 32'hfffff ? c + 1 : c;
    endfunction : sat
    always_ff @(posedge mclk) begin
        req_cnt <= reset || power_on_request_n ? 0 : sat(req_cnt);
        reg_cnt <= reset || !rails_in_regulation || rail_current_limit || !main_rail_enable ? 0 : sat(reg_cnt);
        low_cnt <= reset || scl_in ? 0 : sat(low_cnt);
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    on_min_a: assert property (
        $rose(main_rail_enable) |-> req_cnt >= ON_DELAY_CYC) else $error("main rail rose too early");
    off_resp_a: assert property (
        $rose(power_on_request_n) |-> ##[1:20] !main_rail_enable) else $error("main rail not off");
    good_off_a: assert property (
        $rose(power_on_request_n) |-> ##[1:20] !power_good) else $error("power good not off");
    reg_loss_a: assert property (
        !rails_in_regulation |-> ##2 !power_good) else $error("power good high out of regulation");
    good_main_a: assert property (
        power_good |-> main_rail_enable) else $error("power good without main rail");
    good_min_a: assert property (
        $rose(power_good) |-> reg_cnt + 2 >= GOOD_DELAY_CYC) else $error("power good rose too early");
    in_drop_a: assert property (
        $fell(input_in_range) |-> ##[1:15] !input_good) else $error("input good slow to fall");
    in_rise_a: assert property (
        $rose(input_good) |-> input_in_range) else $error("input good rose without input");
    fault_off_a: assert property (
        (rail_overvoltage || rail_short) && main_rail_enable |-> ##[1:4] !main_rail_enable)
        else $error("fault did not latch off");
    bus_abort_a: assert property (
        low_cnt > CLOCK_LOW_CYC + 16 |-> !sda_oe) else $error("data line held after timeout");
endmodule : pcm_ctrl_monitor
bind pcm_ctrl pcm_ctrl_monitor #(.ON_DELAY_CYC(ON_DELAY_CYC), .GOOD_DELAY_CYC(GOOD_DELAY_CYC),
    .CLOCK_LOW_CYC(CLOCK_LOW_CYC)) u_mon (.mclk(mclk), .reset(reset),
    .power_on_request_n(power_on_request_n), .power_good(power_good), .input_good(input_good),
    .main_rail_enable(main_rail_enable), .input_in_range(input_in_range),
    .rails_in_regulation(rails_in_regulation), .rail_current_limit(rail_current_limit),
    .rail_overvoltage(rail_overvoltage), .rail_short(rail_short), .scl_in(scl_in), .sda_oe(sda_oe));
`default_nettype wire

// ===== pcm_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.svh"
module pcm_ctrl_tb_top;
    import pcm_pkg::*;
    localparam int ON_D = 200;
    localparam int GD = 400;
    localparam int CL = 3000;
    localparam int RC = 1000;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, power_good, input_good, unit_n_a, sda_out, sda_oe, main_en, scl, sda, e, ack;
    logic req_n = 1'b1, a0 = 1'b0, a1 = 1'b0, in_ok = 1'b1, rails_ok = 1'b1, lim = 1'b0, ovp = 1'b0;
    logic shrt = 1'b0;
    logic [7:0] v;
    int n_errors = 0, num_checks = 0;
    always #2 mclk = ~mclk;
    pcm_ctrl #(.ON_DELAY_CYC(ON_D), .GOOD_DELAY_CYC(GD), .CLOCK_LOW_CYC(CL), .RECOVER_CYC(RC),
        .HOLDUP_CYC(300), .DEBOUNCE_CYC(4)) DUT (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_on_request_n(req_n), .slot_addr_bit0(a0),
        .slot_addr_bit1(a1), .power_good(power_good), .input_good(input_good), .unit_n_a(unit_n_a),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .input_in_range(in_ok),
        .rails_in_regulation(rails_ok), .rail_current_limit(lim), .rail_overvoltage(ovp),
        .rail_short(shrt), .main_rail_enable(main_en));
    pcm_bus_host host (.mclk(mclk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask : check_bit
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word
    task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        tick(1);
        penable <= 1'b1;
        tick(1);
        while (pready !== 1'b1) tick(1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask : apb_xfer
    task automatic t_regs;
        apb_xfer(1'b0, 12'h010, 32'h0);
        check_bit(e, 1'b1);
        check_bit(unit_n_a, 1'b0);
        check_bit(main_en, 1'b0);
        apb_xfer(1'b1, `PCM_REG_CTRL, 32'h3);
        req_n <= 1'b0;
        tick(ON_D);
        check_bit(main_en, 1'b0);
        tick(30);
        check_bit(main_en, 1'b1);
        tick(GD - 30);
        check_bit(power_good, 1'b0);
        tick(40);
        check_bit(power_good, 1'b1);
        apb_xfer(1'b0, `PCM_REG_STATUS, 32'h0);
        check_word({27'h0, d[16:12]}, {27'h0, PCM_SEQ_GOOD});
        $display("power up done");
    endtask : t_regs
    task automatic t_power;
        rails_ok <= 1'b0;
        tick(3);
        check_bit(power_good, 1'b0);
        lim <= 1'b1;
        rails_ok <= 1'b1;
        tick(GD + 20);
        check_bit(power_good, 1'b0);
        lim <= 1'b0;
        tick(GD - 5);
        check_bit(power_good, 1'b0);
        tick(30);
        check_bit(power_good, 1'b1);
        req_n <= 1'b1;
        tick(20);
        check_bit(main_en, 1'b0);
        check_bit(power_good, 1'b0);
        req_n <= 1'b0;
        tick(ON_D + 40);
        ovp <= 1'b1;
        tick(1);
        ovp <= 1'b0;
        tick(ON_D);
        check_bit(main_en, 1'b0);
        req_n <= 1'b1;
        tick(30);
        req_n <= 1'b0;
        tick(ON_D + 40);
        check_bit(main_en, 1'b1);
        in_ok <= 1'b0;
        tick(12);
        check_bit(input_good, 1'b0);
        tick(320);
        check_bit(main_en, 1'b0);
        in_ok <= 1'b1;
        tick(20);
        check_bit(input_good, 1'b1);
        $display("power sequencing done");
    endtask : t_power
    task automatic t_bus;
        logic [7:0] ad, p;
        for (int s = 0; s < 4; s++) begin
            {a1, a0} <= s[1:0];
            tick(20);
            ad = 8'ha0 | {5'h0, s[1:0], 1'b0};
            p = 8'hfc + 8'(s);
            host.start_cond();
            host.send_byte(ad, ack);
            check_bit(ack, 1'b1);
            host.send_byte(p, ack);
            host.send_byte(8'h3c ^ p, ack);
            host.start_cond();
            host.send_byte(ad, ack);
            host.send_byte(p, ack);
            host.start_cond();
            host.send_byte(ad | 8'h01, ack);
            host.recv_byte(1'b1, v);
            check_word({24'h0, v}, {24'h0, 8'h3c ^ p});
            host.start_cond();
            host.send_byte(ad ^ 8'h10, ack);
            check_bit(ack, 1'b1);
            host.start_cond();
            host.send_byte(ad ^ 8'h08, ack);
            host.stop_cond();
            check_bit(ack, 1'b0);
        end
        apb_xfer(1'b1, `PCM_REG_STORE_PTR, 32'hff);
        apb_xfer(1'b0, `PCM_REG_STORE_DATA, 32'h0);
        check_word(d, 32'hc3);
        host.start_cond();
        for (int i = 0; i < 3; i++) begin
            host.bit_io(1'b1, e);
            host.runt();
        end
        host.start_cond();
        host.send_byte(8'ha6, ack);
        host.stop_cond();
        check_bit(ack, 1'b1);
        $display("bus addressing done");
    endtask : t_bus
    task automatic t_timeout;
        apb_xfer(1'b1, `PCM_REG_STORE_PTR, 32'h0);
        apb_xfer(1'b1, `PCM_REG_STORE_DATA, 32'h0);
        host.start_cond();
        host.send_byte(8'ha7, ack);
        host.hold_low();
        tick(20);
        check_bit(sda_oe, 1'b1);
        tick(CL);
        check_bit(sda_oe, 1'b0);
        apb_xfer(1'b0, `PCM_REG_STATUS, 32'h0);
        check_bit(d[17], 1'b1);
        host.stop_cond();
        host.start_cond();
        host.send_byte(8'ha6, ack);
        host.stop_cond();
        check_bit(ack, 1'b0);
        tick(RC);
        host.start_cond();
        host.send_byte(8'ha6, ack);
        host.stop_cond();
        check_bit(ack, 1'b1);
        $display("bus timeout done");
    endtask : t_timeout
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        tick(6);
        reset <= 1'b0;
        tick(1);
        t_regs();
        t_power();
        t_bus();
        t_timeout();
        wrap_up();
    end
    initial begin
        tick(40000);
        n_errors++;
        $display("watchdog expired at %0t", $time);
        wrap_up();
    end
endmodule : pcm_ctrl_tb_top
`default_nettype wire

// ===== pcm_map.svh
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH

// clock rate in kHz
`define PCM_CLK_KHZ 250000

// times in ms, debounce in ns
`define PCM_OFF_RESPONSE_MS 5
`define PCM_ON_RESPONSE_MIN_MS 5
`define PCM_ON_RESPONSE_MAX_MS 400
`define PCM_GOOD_DELAY_MIN_MS 100
`define PCM_GOOD_DELAY_MAX_MS 500
`define PCM_INPUT_DROP_MS 2
`define PCM_CLOCK_LOW_MS 25
`define PCM_RECOVER_MS 10
`define PCM_HOLDUP_MS 1
`define PCM_DEBOUNCE_NS 1000

// derived cycle counts
`define PCM_ON_DELAY_CYC (`PCM_ON_RESPONSE_MIN_MS * `PCM_CLK_KHZ)
`define PCM_GOOD_DELAY_CYC (`PCM_GOOD_DELAY_MIN_MS * `PCM_CLK_KHZ)
`define PCM_CLOCK_LOW_CYC (`PCM_CLOCK_LOW_MS * `PCM_CLK_KHZ)
`define PCM_RECOVER_CYC (`PCM_RECOVER_MS * `PCM_CLK_KHZ)
`define PCM_HOLDUP_CYC (`PCM_HOLDUP_MS * `PCM_CLK_KHZ)
`define PCM_DEBOUNCE_CYC ((`PCM_DEBOUNCE_NS * `PCM_CLK_KHZ + 999999) / 1000000)

// target addresses (8-bit form, write bit clear)
`define PCM_MGMT_ADDR_BASE 8'hb0
`define PCM_STORE_ADDR_BASE 8'ha0

// register offsets
`define PCM_REG_CTRL 12'h000
`define PCM_REG_STATUS 12'h004
`define PCM_REG_STORE_PTR 12'h008
`define PCM_REG_STORE_DATA 12'h00c

// control fields and reset value
`define PCM_CTRL_BUS_EN 0
`define PCM_CTRL_STORE_WR_EN 1
`define PCM_CTRL_RESET 2'h1

`endif

// ===== pcm_pkg.sv
package pcm_pkg;
    typedef enum logic [4:0] {
        PCM_SEQ_OFF = 5'h01,
        PCM_SEQ_DELAY = 5'h02,
        PCM_SEQ_RAMP = 5'h04,
        PCM_SEQ_GOOD = 5'h08,
        PCM_SEQ_LATCH = 5'h10
    } pcm_seq_t;

    typedef enum logic [5:0] {
        PCM_BUS_IDLE = 6'h01,
        PCM_BUS_ADDR = 6'h02,
        PCM_BUS_ACK = 6'h04,
        PCM_BUS_WRITE = 6'h08,
        PCM_BUS_READ = 6'h10,
        PCM_BUS_RACK = 6'h20
    } pcm_bus_t;
endpackage : pcm_pkg
